// [rtl/bdt_device.sv]
// transceiver control: registers, burst sequencing, flywheel, power
`timescale 1ns/1ps
`default_nettype none
`include "bdt_cfg.svh"
module bdt_device
   import bdt_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // configuration port
   bdt_if.dev bus,
   // burst requests and matched filter output
   input wire logic tx_start_i,
   input wire logic rx_start_i,
   input wire logic [7:0] corr_mag_i,
   // transmit side
   output logic tx_active_o,
   output logic tx_code_sel_o,
   output logic [7:0] tx_chip_idx_o,
   output logic tx_chip_pulse_o,
   // receive side
   output logic rx_active_o,
   output logic rx_code_sel_o,
   output logic rx_symbol_pulse_o,
   output logic rx_abort_o,
   output logic [7:0] rx_missed_o,
   // power controls
   output logic rx_pwr_o,
   output logic tx_pwr_o,
   output logic nco_pwr_o,
   output logic mf_short_save_o,
   output logic mf_long_save_o
);
   function automatic logic [7:0] len_min1(input logic [7:0] v);
      len_min1 = (v == 8'h00) ? 8'h01 : v;
   endfunction : len_min1
   function automatic logic [15:0] burst_eff(input logic [15:0] v);
      burst_eff = (v == 16'h0000) ? 16'h0001 :
         ((v > `BDT_BURST_MAX) ? `BDT_BURST_MAX : v);
   endfunction : burst_eff
   logic [7:0] ctrl_ff, thresh_ff, pre_len_ff, data_len_ff;
   logic [7:0] miss_lim_ff, gate_ff, div_ff;
   logic [7:0] nxt_ctrl, nxt_thresh, nxt_pre_len, nxt_data_len;
   logic [7:0] nxt_miss_lim, nxt_gate, nxt_div;
   logic [15:0] burst_ff, nxt_burst;
   logic wr_n_q_ff, wr_fire;
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_burst = burst_ff;
      nxt_thresh = thresh_ff;
      nxt_pre_len = pre_len_ff;
      nxt_data_len = data_len_ff;
      nxt_miss_lim = miss_lim_ff;
      nxt_gate = gate_ff;
      nxt_div = div_ff;
      wr_fire = ~bus.chip_select_n & ~bus.write_strobe_n & wr_n_q_ff;
      if (wr_fire) begin
         unique case (bus.addr)
            `BDT_OFS_CTRL: nxt_ctrl = bus.data;
            `BDT_OFS_BURST_LO: nxt_burst = {burst_ff[15:8], bus.data};
            `BDT_OFS_BURST_HI: nxt_burst = {bus.data, burst_ff[7:0]};
            `BDT_OFS_THRESH: nxt_thresh = bus.data;
            `BDT_OFS_PRE_LEN: nxt_pre_len = bus.data;
            `BDT_OFS_DATA_LEN: nxt_data_len = bus.data;
            `BDT_OFS_MISS_LIM: nxt_miss_lim = bus.data;
            `BDT_OFS_GATE: nxt_gate = bus.data;
            `BDT_OFS_CHIP_DIV: nxt_div = bus.data;
            default: ;
         endcase
      end
   end
   logic sleep, rx_pwr, tx_pwr, cont, chip_tick;
   logic [7:0] div_cnt_ff, nxt_div_cnt, div_eff, pre_len, data_len;
   logic [15:0] burst_len;
   always_comb begin
      sleep = ctrl_ff[`BDT_CTRL_SLEEP];
      rx_pwr = ctrl_ff[`BDT_CTRL_RX_EN] & bus.manual_rx_enable & ~sleep;
      tx_pwr = ctrl_ff[`BDT_CTRL_TX_EN] & bus.manual_tx_enable & ~sleep;
      cont = ctrl_ff[`BDT_CTRL_CONT];
      // chip rate held at or below a quarter clock
      div_eff = (div_ff < `BDT_CHIP_DIV_MIN) ? `BDT_CHIP_DIV_MIN : div_ff;
      pre_len = len_min1(pre_len_ff);
      data_len = len_min1(data_len_ff);
      burst_len = burst_eff(burst_ff);
      // one chip rate for both codes
      chip_tick = (div_cnt_ff == 8'(div_eff - 8'h01));
      nxt_div_cnt = chip_tick ? 8'h00 : 8'(div_cnt_ff + 8'h01);
   end
   bdt_tx_st_e tx_st_ff, nxt_tx_st;
   logic [7:0] tx_chip_ff, nxt_tx_chip;
   logic [15:0] tx_sym_ff, nxt_tx_sym;
   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_chip = tx_chip_ff;
      nxt_tx_sym = tx_sym_ff;
      unique case (tx_st_ff)
         BDT_TX_IDLE: begin
            if (tx_start_i & tx_pwr) begin
               nxt_tx_st = BDT_TX_PRE;
               nxt_tx_chip = 8'h00;
               nxt_tx_sym = 16'h0000;
            end
         end
         BDT_TX_PRE: begin
            // code restarts at the symbol edge
            if (chip_tick & (tx_chip_ff == 8'(pre_len - 8'h01))) begin
               nxt_tx_st = BDT_TX_DATA;
               nxt_tx_chip = 8'h00;
            end else if (chip_tick) begin
               nxt_tx_chip = 8'(tx_chip_ff + 8'h01);
            end
         end
         BDT_TX_DATA: begin
            if (chip_tick & (tx_chip_ff == 8'(data_len - 8'h01))) begin
               nxt_tx_chip = 8'h00;
               nxt_tx_sym = 16'(tx_sym_ff + 16'h0001);
               if (!cont & (16'(tx_sym_ff + 16'h0001) == burst_len)) begin
                  nxt_tx_st = BDT_TX_IDLE;
               end
            end else if (chip_tick) begin
               nxt_tx_chip = 8'(tx_chip_ff + 8'h01);
            end
         end
         default: nxt_tx_st = BDT_TX_IDLE;
      endcase
      // disabling the transmitter stops the burst
      if (!tx_pwr) begin
         nxt_tx_st = BDT_TX_IDLE;
      end
   end
   bdt_rx_st_e rx_st_ff, nxt_rx_st;
   logic [7:0] rx_chip_ff, nxt_rx_chip, miss_ff, nxt_miss;
   logic [15:0] rx_sym_ff, nxt_rx_sym;
   logic peak, in_gate, last_chip, nxt_sym_pls, nxt_abort;
   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_chip = rx_chip_ff;
      nxt_rx_sym = rx_sym_ff;
      nxt_miss = miss_ff;
      nxt_sym_pls = 1'b0;
      nxt_abort = 1'b0;
      peak = chip_tick & (corr_mag_i >= thresh_ff);
      last_chip = (rx_chip_ff == 8'(data_len - 8'h01));
      // peaks count only near the expected instant
      in_gate = (9'(rx_chip_ff) + 9'(gate_ff)) >= 9'(8'(data_len - 8'h01));
      unique case (rx_st_ff)
         BDT_RX_IDLE: begin
            if (rx_start_i & rx_pwr) begin
               nxt_rx_st = BDT_RX_ACQ;
               nxt_miss = 8'h00;
            end
         end
         BDT_RX_ACQ: begin
            // one preamble peak sets symbol timing
            if (peak) begin
               nxt_rx_st = BDT_RX_TRACK;
               nxt_rx_chip = 8'h00;
               nxt_rx_sym = 16'h0000;
               nxt_sym_pls = 1'b1;
            end
         end
         BDT_RX_TRACK: begin
            if (chip_tick & ((peak & in_gate) | last_chip)) begin
               // pulse issued even without a peak
               nxt_sym_pls = 1'b1;
               nxt_rx_chip = 8'h00;
               nxt_rx_sym = 16'(rx_sym_ff + 16'h0001);
               if (!(peak & in_gate) & (miss_ff != 8'hff)) begin
                  nxt_miss = 8'(miss_ff + 8'h01);
               end
               if (!cont & (16'(rx_sym_ff + 16'h0001) == burst_len)) begin
                  nxt_rx_st = BDT_RX_IDLE;
               end
               // too many misses aborts the burst
               if ((miss_lim_ff != 8'h00) & (nxt_miss >= miss_lim_ff)) begin
                  nxt_rx_st = BDT_RX_IDLE;
                  nxt_abort = 1'b1;
               end
            end else if (chip_tick) begin
               nxt_rx_chip = 8'(rx_chip_ff + 8'h01);
            end
         end
         default: nxt_rx_st = BDT_RX_IDLE;
      endcase
      if (!rx_pwr) begin
         nxt_rx_st = BDT_RX_IDLE;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_ff <= 8'h00;
         ctrl_ff <= `BDT_RST_CTRL;
         burst_ff <= `BDT_RST_BURST;
         thresh_ff <= `BDT_RST_THRESH;
         pre_len_ff <= `BDT_RST_PRE_LEN;
         data_len_ff <= `BDT_RST_DATA_LEN;
         miss_lim_ff <= `BDT_RST_MISS_LIM;
         gate_ff <= `BDT_RST_GATE;
         div_ff <= `BDT_RST_CHIP_DIV;
         wr_n_q_ff <= 1'b1;
         tx_st_ff <= BDT_TX_IDLE;
         tx_chip_ff <= 8'h00;
         tx_sym_ff <= 16'h0000;
         rx_st_ff <= BDT_RX_IDLE;
         rx_chip_ff <= 8'h00;
         rx_sym_ff <= 16'h0000;
         miss_ff <= 8'h00;
         tx_active_o <= 1'b0;
         tx_code_sel_o <= 1'b0;
         tx_chip_idx_o <= 8'h00;
         tx_chip_pulse_o <= 1'b0;
         rx_active_o <= 1'b0;
         rx_code_sel_o <= 1'b0;
         rx_symbol_pulse_o <= 1'b0;
         rx_abort_o <= 1'b0;
         rx_missed_o <= 8'h00;
         rx_pwr_o <= 1'b0;
         tx_pwr_o <= 1'b0;
         nco_pwr_o <= 1'b0;
         mf_short_save_o <= 1'b0;
         mf_long_save_o <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         ctrl_ff <= nxt_ctrl;
         burst_ff <= nxt_burst;
         thresh_ff <= nxt_thresh;
         pre_len_ff <= nxt_pre_len;
         data_len_ff <= nxt_data_len;
         miss_lim_ff <= nxt_miss_lim;
         gate_ff <= nxt_gate;
         div_ff <= nxt_div;
         wr_n_q_ff <= bus.write_strobe_n;
         tx_st_ff <= nxt_tx_st;
         tx_chip_ff <= nxt_tx_chip;
         tx_sym_ff <= nxt_tx_sym;
         rx_st_ff <= nxt_rx_st;
         rx_chip_ff <= nxt_rx_chip;
         rx_sym_ff <= nxt_rx_sym;
         miss_ff <= nxt_miss;
         tx_active_o <= (nxt_tx_st != BDT_TX_IDLE);
         // code select follows the symbol type
         tx_code_sel_o <= (nxt_tx_st == BDT_TX_DATA);
         tx_chip_idx_o <= nxt_tx_chip;
         tx_chip_pulse_o <= chip_tick & (tx_st_ff != BDT_TX_IDLE);
         rx_active_o <= (nxt_rx_st != BDT_RX_IDLE);
         rx_code_sel_o <= (nxt_rx_st == BDT_RX_TRACK);
         rx_symbol_pulse_o <= nxt_sym_pls;
         rx_abort_o <= nxt_abort;
         rx_missed_o <= nxt_miss;
         rx_pwr_o <= rx_pwr;
         tx_pwr_o <= tx_pwr;
         // NCO off for transmit on an external modulator
         nco_pwr_o <= ctrl_ff[`BDT_CTRL_NCO_EN] & ~sleep &
            (rx_pwr | (tx_pwr & ~ctrl_ff[`BDT_CTRL_EXT_MOD]));
         // filter power saving only while the receiver is powered (rx_pwr), not tied to a burst
         mf_short_save_o <= ctrl_ff[`BDT_CTRL_MF_SHORT] & rx_pwr;
         mf_long_save_o <= ctrl_ff[`BDT_CTRL_MF_LONG] & rx_pwr;
      end
   end
endmodule : bdt_device
`default_nettype wire

// [rtl/bdt_cfg.svh]
// constants for the burst spread-spectrum transceiver control block
`ifndef BDT_CFG_SVH
`define BDT_CFG_SVH

`define BDT_ADDR_W 7
`define BDT_DATA_W 8

// register offsets
`define BDT_OFS_CTRL 7'h00
`define BDT_OFS_BURST_LO 7'h01
`define BDT_OFS_BURST_HI 7'h02
`define BDT_OFS_THRESH 7'h03
`define BDT_OFS_PRE_LEN 7'h04
`define BDT_OFS_DATA_LEN 7'h05
`define BDT_OFS_MISS_LIM 7'h06
`define BDT_OFS_GATE 7'h07
`define BDT_OFS_CHIP_DIV 7'h08

// control register bits
`define BDT_CTRL_RX_EN 0
`define BDT_CTRL_TX_EN 1
`define BDT_CTRL_NCO_EN 2
`define BDT_CTRL_CONT 3
`define BDT_CTRL_MF_SHORT 4
`define BDT_CTRL_MF_LONG 5
`define BDT_CTRL_SLEEP 6
`define BDT_CTRL_EXT_MOD 7

// reset values
`define BDT_RST_CTRL 8'h00
`define BDT_RST_BURST 16'h0010
`define BDT_RST_THRESH 8'h80
`define BDT_RST_PRE_LEN 8'h40
`define BDT_RST_DATA_LEN 8'h0b
`define BDT_RST_MISS_LIM 8'h00
`define BDT_RST_GATE 8'h01
`define BDT_RST_CHIP_DIV 8'h04

`define BDT_BURST_MAX 16'hfffd
`define BDT_CHIP_DIV_MIN 8'h04

// host write timing
`define BDT_CLK_NS 4
`define BDT_T_SU_NS 5
`define BDT_T_W_NS 5
`define BDT_T_HD_NS 5
`define BDT_SU_CYC ((`BDT_T_SU_NS + `BDT_CLK_NS - 1) / `BDT_CLK_NS)
`define BDT_W_CYC ((`BDT_T_W_NS + `BDT_CLK_NS - 1) / `BDT_CLK_NS)
`define BDT_HD_CYC ((`BDT_T_HD_NS + `BDT_CLK_NS - 1) / `BDT_CLK_NS)

`endif

// [rtl/bdt_pkg.sv]
// types for the burst spread-spectrum transceiver control block
package bdt_pkg;
   typedef enum logic [1:0] {
      BDT_TX_IDLE = 2'b00,
      BDT_TX_PRE = 2'b01,
      BDT_TX_DATA = 2'b10
   } bdt_tx_st_e;
   typedef enum logic [1:0] {
      BDT_RX_IDLE = 2'b00,
      BDT_RX_ACQ = 2'b01,
      BDT_RX_TRACK = 2'b10
   } bdt_rx_st_e;
   typedef enum logic [1:0] {
      BDT_H_IDLE = 2'b00,
      BDT_H_SETUP = 2'b01,
      BDT_H_STROBE = 2'b10,
      BDT_H_HOLD = 2'b11
   } bdt_host_st_e;
endpackage : bdt_pkg

// [rtl/bdt_if.sv]
// configuration port between host controller and transceiver
`timescale 1ns/1ps
`default_nettype none
`include "bdt_cfg.svh"
interface bdt_if;
   logic chip_select_n;
   logic write_strobe_n;
   logic [`BDT_ADDR_W-1:0] addr;
   logic [`BDT_DATA_W-1:0] data;
   logic manual_tx_enable;
   logic manual_rx_enable;
   modport host (
      output chip_select_n, write_strobe_n, addr, data,
      output manual_tx_enable, manual_rx_enable
   );
   modport dev (
      input chip_select_n, write_strobe_n, addr, data,
      input manual_tx_enable, manual_rx_enable
   );
endinterface : bdt_if
`default_nettype wire

// [rtl/bdt_host.sv]
// host end: turns queued register writes into strobed port cycles
`timescale 1ns/1ps
`default_nettype none
`include "bdt_cfg.svh"
module bdt_host
   import bdt_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // configuration port
   bdt_if.host bus,
   // write requests
   input wire logic cmd_valid_i,
   input wire logic [`BDT_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`BDT_DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   // manual enables
   input wire logic man_tx_en_i,
   input wire logic man_rx_en_i
);
   bdt_host_st_e st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic cs_n_ff, nxt_cs_n, wr_n_ff, nxt_wr_n;
   logic [`BDT_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [`BDT_DATA_W-1:0] data_ff, nxt_data;
   logic mtx_ff, mrx_ff;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_cs_n = cs_n_ff;
      nxt_wr_n = wr_n_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      unique case (st_ff)
         BDT_H_IDLE: begin
            if (cmd_valid_i) begin
               nxt_st = BDT_H_SETUP;
               nxt_cs_n = 1'b0;
               nxt_addr = cmd_addr_i;
               nxt_data = cmd_data_i;
               nxt_cnt = 4'(`BDT_SU_CYC - 1);
            end
         end
         BDT_H_SETUP: begin
            if (cnt_ff == 4'h0) begin
               nxt_st = BDT_H_STROBE;
               nxt_wr_n = 1'b0;
               nxt_cnt = 4'(`BDT_W_CYC - 1);
            end else begin
               nxt_cnt = 4'(cnt_ff - 4'h1);
            end
         end
         BDT_H_STROBE: begin
            if (cnt_ff == 4'h0) begin
               nxt_st = BDT_H_HOLD;
               nxt_wr_n = 1'b1;
               nxt_cnt = 4'(`BDT_HD_CYC - 1);
            end else begin
               nxt_cnt = 4'(cnt_ff - 4'h1);
            end
         end
         BDT_H_HOLD: begin
            // select, address and data held past the strobe
            if (cnt_ff == 4'h0) begin
               nxt_st = BDT_H_IDLE;
               nxt_cs_n = 1'b1;
            end else begin
               nxt_cnt = 4'(cnt_ff - 4'h1);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= BDT_H_IDLE;
         cnt_ff <= 4'h0;
         cs_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         addr_ff <= 7'h00;
         data_ff <= 8'h00;
         mtx_ff <= 1'b0;
         mrx_ff <= 1'b0;
         cmd_ready_o <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         cs_n_ff <= nxt_cs_n;
         wr_n_ff <= nxt_wr_n;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         mtx_ff <= man_tx_en_i;
         mrx_ff <= man_rx_en_i;
         cmd_ready_o <= (nxt_st == BDT_H_IDLE) & ~(st_ff == BDT_H_IDLE &
            cmd_valid_i);
      end
   end

   assign bus.chip_select_n = cs_n_ff;
   assign bus.write_strobe_n = wr_n_ff;
   assign bus.addr = addr_ff;
   assign bus.data = data_ff;
   assign bus.manual_tx_enable = mtx_ff;
   assign bus.manual_rx_enable = mrx_ff;
endmodule : bdt_host
`default_nettype wire

// [testbench/bdt_port_asserts.sv]
// timing checks on the configuration wires between host and device
`timescale 1ns/1ps
`default_nettype none
`include "bdt_cfg.svh"
module bdt_port_asserts (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // configuration wires
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic [`BDT_ADDR_W-1:0] addr,
   input wire logic [`BDT_DATA_W-1:0] data
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence setup_s;
      (write_strobe_n && !chip_select_n) [*2];
   endsequence
   sequence strobe_s;
      (!write_strobe_n && !chip_select_n) [*2];
   endsequence
   // select lingers after the strobe so the device never sees a torn write
   sequence hold_s;
      (write_strobe_n && !chip_select_n) [*2] ##1 chip_select_n;
   endsequence
   cycle_shape_a: assert property (
      $fell(chip_select_n) |-> setup_s ##1 strobe_s ##1 hold_s)
      else $error("write cycle shape wrong");
   strobe_in_select_a: assert property (
      !write_strobe_n |-> !chip_select_n)
      else $error("strobe low without select");
   strobe_width_a: assert property (
      $fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
      else $error("strobe width not two cycles");
   hold_time_a: assert property (
      $rose(write_strobe_n) |-> hold_s)
      else $error("select released too early");
   setup_time_a: assert property (
      $fell(write_strobe_n) |-> $past(chip_select_n, 2) == 1'b0)
      else $error("strobe fell too soon after select");
   addr_stable_a: assert property (
      !chip_select_n && $past(!chip_select_n) |-> $stable(addr))
      else $error("address moved during write");
   data_stable_a: assert property (
      !chip_select_n && $past(!chip_select_n) |-> $stable(data))
      else $error("data moved during write");
   select_width_a: assert property (
      $fell(chip_select_n) |-> !chip_select_n [*6] ##1 chip_select_n)
      else $error("select not six cycles");
   cover property ($fell(write_strobe_n));
endmodule : bdt_port_asserts
`default_nettype wire

// [testbench/burst_dsss_transceiver_control_bench.sv]
// self-checking bench: host end and device end joined by the port
`timescale 1ns/1ps
`default_nettype none
module burst_dsss_transceiver_control_bench;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_valid = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready;
   logic man_tx = 1'b1;
   logic man_rx = 1'b1;
   logic tx_start = 1'b0;
   logic rx_start = 1'b0;
   logic [7:0] corr = 8'h00;
   logic tx_active, tx_code, tx_pulse, rx_active, rx_code, rx_sym, rx_abort;
   logic [7:0] tx_idx, rx_missed;
   wire logic [4:0] pwr;
   wire logic [4:0] pwr2;
   int n_errors = 0;
   int tests_run = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   bdt_if bus_if ();
   bdt_if bus2_if ();
   bdt_host bdt_host_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .bus(bus_if.host), .cmd_valid_i(cmd_valid), .cmd_addr_i(cmd_addr),
      .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
      .man_tx_en_i(man_tx), .man_rx_en_i(man_rx));
   bdt_device bdt_device_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .bus(bus_if.dev), .tx_start_i(tx_start), .rx_start_i(rx_start),
      .corr_mag_i(corr), .tx_active_o(tx_active), .tx_code_sel_o(tx_code),
      .tx_chip_idx_o(tx_idx), .tx_chip_pulse_o(tx_pulse),
      .rx_active_o(rx_active),
      .rx_code_sel_o(rx_code), .rx_symbol_pulse_o(rx_sym),
      .rx_abort_o(rx_abort), .rx_missed_o(rx_missed), .rx_pwr_o(pwr[4]),
      .tx_pwr_o(pwr[3]), .nco_pwr_o(pwr[2]), .mf_short_save_o(pwr[1]),
      .mf_long_save_o(pwr[0]));
   // second device faces a bench driver that breaks the port rules
   bdt_device bdt_device_inst2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .bus(bus2_if.dev), .tx_start_i(tx_start), .rx_start_i(rx_start),
      .corr_mag_i(corr), .tx_active_o(), .tx_code_sel_o(),
      .tx_chip_idx_o(), .tx_chip_pulse_o(), .rx_active_o(),
      .rx_code_sel_o(), .rx_symbol_pulse_o(), .rx_abort_o(),
      .rx_missed_o(), .rx_pwr_o(pwr2[4]), .tx_pwr_o(pwr2[3]),
      .nco_pwr_o(pwr2[2]), .mf_short_save_o(pwr2[1]),
      .mf_long_save_o(pwr2[0]));
   bdt_port_asserts bdt_port_asserts_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .chip_select_n(bus_if.chip_select_n),
      .write_strobe_n(bus_if.write_strobe_n), .addr(bus_if.addr),
      .data(bus_if.data));
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // one host write; the wait covers strobe capture plus output update
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      check(16'(cmd_ready), 16'h0001);
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      cyc(1);
      cmd_valid = 1'b0;
      check(16'(cmd_ready), 16'h0000);
      cyc(9);
   endtask : wr
   task automatic wr2(input logic cs_n, input logic [6:0] a,
                      input logic [7:0] d);
      bus2_if.chip_select_n = cs_n;
      bus2_if.addr = a;
      bus2_if.data = d;
      cyc(2);
      bus2_if.write_strobe_n = 1'b0;
      cyc(2);
      bus2_if.write_strobe_n = 1'b1;
      cyc(2);
      bus2_if.chip_select_n = 1'b1;
      cyc(3);
   endtask : wr2
   task automatic pulse_start(input logic tx);
      if (tx) tx_start = 1'b1;
      else rx_start = 1'b1;
      cyc(1);
      tx_start = 1'b0;
      rx_start = 1'b0;
   endtask : pulse_start
   task automatic wait_sym(output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (rx_sym !== 1'b1 && n < 300);
   endtask : wait_sym
   task automatic test_power();
      logic [7:0] ctl [6] = '{8'h03, 8'h07, 8'h86, 8'h47, 8'h31, 8'h03};
      logic [4:0] exp [6] = '{5'h18, 5'h1c, 5'h08, 5'h00, 5'h13, 5'h08};
      for (int i = 0; i < 6; i++) begin
         man_rx = (i != 5);
         wr(7'h00, ctl[i]);
         check(16'(pwr), 16'(exp[i]));
      end
      man_rx = 1'b1;
      $display("test power done");
   endtask : test_power
   task automatic test_tx();
      int n, sw, wraps, pulses;
      logic seen, prev;
      logic [7:0] mx0, mx1, last;
      wr(7'h04, 8'h04);
      wr(7'h05, 8'h03);
      wr(7'h01, 8'h03);
      wr(7'h02, 8'h00);
      wr(7'h00, 8'h02);
      pulse_start(1'b1);
      {sw, wraps, seen, prev, mx0, mx1, last} = '0;
      pulses = 0;
      for (n = 0; n < 400; n++) begin
         if (tx_pulse === 1'b1) pulses++;
         if (tx_active !== 1'b1) begin
            if (seen) break;
         end else begin
            seen = 1'b1;
            if (tx_code && !prev) sw++;
            prev = tx_code;
            if (!tx_code) begin
               if (tx_idx > mx0) mx0 = tx_idx;
               last = 8'h00;
            end else begin
               if (tx_idx == 8'h00 && last != 8'h00) wraps++;
               if (tx_idx > mx1) mx1 = tx_idx;
               last = tx_idx;
            end
         end
         cyc(1);
      end
      check(16'(mx0), 16'h0003);
      check(16'(mx1), 16'h0002);
      check(16'(sw), 16'h0001);
      check(16'(wraps), 16'h0002);
      check(16'(n < 400), 16'h0001);
      check(16'(pulses), 16'd13);
      wr(7'h00, 8'h0a);
      pulse_start(1'b1);
      cyc(300);
      check(16'(tx_active), 16'h0001);
      wr(7'h00, 8'h00);
      check(16'(tx_active), 16'h0000);
      $display("test tx done");
   endtask : test_tx
   task automatic test_rx_gate();
      int n;
      wr(7'h01, 8'h04);
      wr(7'h06, 8'h00);
      wr(7'h00, 8'h01);
      wr(7'h08, 8'h02);
      corr = 8'hff;
      for (int g = 0; g < 2; g++) begin
         wr(7'h07, 8'(g));
         pulse_start(1'b0);
         wait_sym(n);
         check(16'(rx_code), 16'h0001);
         wait_sym(n);
         wait_sym(n);
         check(16'(n), 16'((3 - g) * 4));
         check(16'(rx_missed), 16'h0000);
         n = 0;
         while (rx_active === 1'b1 && n < 300) begin
            cyc(1);
            n++;
         end
         check(16'(rx_active), 16'h0000);
      end
      $display("test rx gate done");
   endtask : test_rx_gate
   task automatic test_rx_miss();
      int n;
      wr(7'h06, 8'h02);
      wr(7'h07, 8'h01);
      wr(7'h08, 8'h05);
      corr = 8'hff;
      pulse_start(1'b0);
      wait_sym(n);
      corr = 8'h00;
      wait_sym(n);
      check(16'(n), 16'd15);
      check(16'(rx_missed), 16'h0001);
      n = 0;
      while (rx_abort !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      check(16'(rx_abort), 16'h0001);
      check(16'(rx_missed), 16'h0002);
      check(16'(rx_active), 16'h0000);
      $display("test rx miss done");
   endtask : test_rx_miss
   task automatic test_port2();
      wr2(1'b1, 7'h00, 8'h03);
      check(16'(pwr2), 16'h0000);
      wr2(1'b0, 7'h40, 8'h03);
      check(16'(pwr2), 16'h0000);
      wr2(1'b0, 7'h00, 8'h03);
      check(16'(pwr2), 16'h0018);
      $display("test port faults done");
   endtask : test_port2
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      bus2_if.chip_select_n = 1'b1;
      bus2_if.write_strobe_n = 1'b1;
      bus2_if.addr = 7'h00;
      bus2_if.data = 8'h00;
      bus2_if.manual_tx_enable = 1'b1;
      bus2_if.manual_rx_enable = 1'b1;
      cyc(8);
      rst_n_i = 1'b1;
      cyc(2);
      check(16'(pwr), 16'h0000);
      test_power();
      test_tx();
      test_rx_gate();
      test_rx_miss();
      test_port2();
      tally_and_finish();
   end
   // the tests need under a thousand cycles; this is ample margin
   initial begin
      #80000;
      n_errors++;
      tally_and_finish();
   end
endmodule : burst_dsss_transceiver_control_bench
`default_nettype wire
